// file: pkg/ppp_regs.svh
/*
 * Constants of the parallel programming port: command codes, action codes,
 * memory geometry, fuse reset values and timing counts.
 * Assumes a 40 MHz core clock; included by bare name.
 */
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH

// ****************************************
// Action select codes {hi, lo}
// ****************************************
`define PPP_ACT_ADDR      2'h0
`define PPP_ACT_DATA      2'h1
`define PPP_ACT_CMD       2'h2
`define PPP_ACT_IDLE      2'h3

// ****************************************
// Command byte codes
// ****************************************
`define PPP_CMD_NOP       8'h00
`define PPP_CMD_ERASE     8'h80
`define PPP_CMD_WR_FUSE   8'h40
`define PPP_CMD_WR_LOCK   8'h20
`define PPP_CMD_WR_FLASH  8'h10
`define PPP_CMD_WR_EE     8'h11
`define PPP_CMD_RD_SIG    8'h08
`define PPP_CMD_RD_FUSE   8'h04
`define PPP_CMD_RD_FLASH  8'h02
`define PPP_CMD_RD_EE     8'h03

// ****************************************
// Memory geometry
// ****************************************
`define PPP_FL_AW         12
`define PPP_EE_AW         9
`define PPP_FL_PAGE_AW    5
`define PPP_EE_PAGE_AW    2
`define PPP_FL_PAGE       13'h0020
`define PPP_EE_PAGE       13'h0004
`define PPP_FL_LAST       13'h0fff
`define PPP_EE_WORDS      13'h0200

// ****************************************
// Fuse and lock reset values, field positions
// ****************************************
`define PPP_FUSE_LO_RST   8'h62
`define PPP_FUSE_HI_RST   8'hdf
`define PPP_FUSE_EXT_RST  8'hff
`define PPP_LOCK_RST      8'hff
`define PPP_KEEP_EE_BIT   6

// ****************************************
// Timing
// ****************************************
`define PPP_CLK_MHZ       40
`define PPP_T_ENTRY_NS    100
`define PPP_ENTRY_CYC     ((`PPP_T_ENTRY_NS * `PPP_CLK_MHZ + 999) / 1000)
`define PPP_ENTRY_TOGGLES 6
`define PPP_T_FLASH_US    4500
`define PPP_T_EE_US       4000
`define PPP_T_ERASE_US    9000
`define PPP_T_FUSE_US     4500
`define PPP_FLASH_CYC     (`PPP_T_FLASH_US * `PPP_CLK_MHZ)
`define PPP_EE_CYC        (`PPP_T_EE_US * `PPP_CLK_MHZ)
`define PPP_ERASE_CYC     (`PPP_T_ERASE_US * `PPP_CLK_MHZ)
`define PPP_FUSE_CYC      (`PPP_T_FUSE_US * `PPP_CLK_MHZ)

`endif

// file: pkg/ppp_pkg.sv
/*
 * Types of the parallel programming port: entry and operation states and
 * the packed state record of the top module.
 * Assumes nothing beyond the constant header.
 */
`default_nettype none

package ppp_pkg;

    typedef enum logic [4:0] {
        EN_OFF    = 5'h01,
        EN_ARMED  = 5'h02,
        EN_SETTLE = 5'h04,
        EN_ACTIVE = 5'h08,
        EN_FAIL   = 5'h10
    } ppp_entry_t;

    typedef enum logic [3:0] {
        OP_IDLE  = 4'h1,
        OP_COPY  = 4'h2,
        OP_ERASE = 4'h4,
        OP_WAIT  = 4'h8
    } ppp_op_t;

    typedef struct packed {
        ppp_entry_t  en;
        ppp_op_t     op;
        logic [2:0]  tog_cnt;
        logic [2:0]  settle;
        logic        lclk_q;
        logic        wr_n_q;
        logic        bsf_q;
        logic [7:0]  cmd;
        logic [7:0]  addr_lo;
        logic [7:0]  addr_hi;
        logic [7:0]  data_lo;
        logic [7:0]  data_hi;
        logic        dirty;
        logic [12:0] cnt;
        logic [19:0] wait_cnt;
        logic [19:0] wait_len;
        logic [7:0]  fuse_lo;
        logic [7:0]  fuse_hi;
        logic [7:0]  fuse_ext;
        logic [7:0]  lock;
        logic [7:0]  dout;
        logic        doe;
        logic        rdy;
        logic        pm;
    } ppp_state_t;

endpackage

`default_nettype wire

// file: rtl/ppp_mem.sv
/*
 * Simple dual-port memory with a registered read port.
 * Assumes one clock; contents are not reset, only the read register is.
 */
`default_nettype none

module ppp_mem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output var  logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read after write to the same word returns the old data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

// file: rtl/ppp_port.sv
/*
 * Parallel high-voltage programming port: entry detection, command, address
 * and data loading, page buffers, page write, chip erase, fuse and lock
 * access and read-back onto the data bus.
 * Assumes all pins are synchronous to clk; reset_low and reset_hv report the
 * reset pin at 0 V and at the high programming voltage.
 */
// What this block does
// - Second action bit doubles as byte select two
// - Byte select one picks byte, latches pages
// - Drive data bus only while output enable low
// - Ready flag low while busy, high when idle
// - Entry pins all zero when high voltage arrives
// - Load clock rise loads address, data or command
// - Write or output enable runs the loaded command
// - Decode erase, write fuse, write lock
// - Decode write flash, write eeprom, read signature
// - Decode read fuse/lock, read flash, read eeprom
// - Entry pins steady 100 ns or entry fails
// - Command and address kept across operations
// - Erase clears memories, then locks; fuses kept
// - Keep-eeprom fuse spares eeprom on erase
// - Write pulse starts erase; no loads while busy
// - Command zero is no-op, drops page session
// - Write pulse programs whole flash page buffer
// - Read flash byte chosen by byte select one
// - Byte selects pick fuse low/high/extended/lock
`include "ppp_regs.svh"

`default_nettype none

module ppp_port #(
    parameter logic [19:0] FLASH_WAIT = 20'(`PPP_FLASH_CYC),
    parameter logic [19:0] EE_WAIT    = 20'(`PPP_EE_CYC),
    parameter logic [19:0] ERASE_WAIT = 20'(`PPP_ERASE_CYC),
    parameter logic [19:0] FUSE_WAIT  = 20'(`PPP_FUSE_CYC),
    parameter logic [7:0]  SIG_BYTE0  = 8'h5a,  // Arbitrary identity value
    parameter logic [7:0]  SIG_BYTE1  = 8'h01,  // Arbitrary identity value
    parameter logic [7:0]  SIG_BYTE2  = 8'h02,  // Arbitrary identity value
    parameter logic [7:0]  CAL_BYTE   = 8'h80
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       reset_low,
    input  wire logic       reset_hv,
    input  wire logic       load_clock_in,
    input  wire logic       action_sel_lo,
    input  wire logic       action_sel_hi,
    input  wire logic       byte_select_first,
    input  wire logic       write_n,
    input  wire logic       oe_n,
    input  wire logic [7:0] data_in,
    output var  logic [7:0] data_out,
    output var  logic       data_oe,
    output var  logic       ready_busy_flag,
    output var  logic       prog_mode
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ****************************************
    // Memories
    // ****************************************
    logic                       fl_we, ee_we, fb_we, eb_we;
    logic [`PPP_FL_AW-1:0]      fl_wa, fl_ra;
    logic [`PPP_EE_AW-1:0]      ee_wa, ee_ra;
    logic [`PPP_FL_PAGE_AW-1:0] fb_wa, fb_ra;
    logic [`PPP_EE_PAGE_AW-1:0] eb_wa, eb_ra;
    logic [15:0]                fl_wd, fl_rd, fb_wd, fb_rd;
    logic [7:0]                 ee_wd, ee_rd, eb_wd, eb_rd;

    ppp_mem #(.AW(`PPP_FL_AW), .DW(16)) u_flash (
        .clk(clk), .rst_n(rst_n), .ce(ce), .we(fl_we), .waddr(fl_wa),
        .wdata(fl_wd), .raddr(fl_ra), .rdata(fl_rd)
    );
    ppp_mem #(.AW(`PPP_EE_AW), .DW(8)) u_eeprom (
        .clk(clk), .rst_n(rst_n), .ce(ce), .we(ee_we), .waddr(ee_wa),
        .wdata(ee_wd), .raddr(ee_ra), .rdata(ee_rd)
    );
    ppp_mem #(.AW(`PPP_FL_PAGE_AW), .DW(16)) u_flash_buf (
        .clk(clk), .rst_n(rst_n), .ce(ce), .we(fb_we), .waddr(fb_wa),
        .wdata(fb_wd), .raddr(fb_ra), .rdata(fb_rd)
    );
    ppp_mem #(.AW(`PPP_EE_PAGE_AW), .DW(8)) u_ee_buf (
        .clk(clk), .rst_n(rst_n), .ce(ce), .we(eb_we), .waddr(eb_wa),
        .wdata(eb_wd), .raddr(eb_ra), .rdata(eb_rd)
    );

    // ****************************************
    // State
    // ****************************************
    ppp_pkg::ppp_state_t s, next_s;

    logic        lclk_rise, lclk_tog, wr_fall, pgl_rise, copy_ee, keep_ee;
    logic [3:0]  pen;
    logic [12:0] cm1;

    always_comb begin
        next_s    = s;
        lclk_rise = load_clock_in & ~s.lclk_q;
        lclk_tog  = load_clock_in ^ s.lclk_q;
        wr_fall   = ~write_n & s.wr_n_q;
        pgl_rise  = byte_select_first & ~s.bsf_q;
        pen       = {byte_select_first, action_sel_hi, action_sel_lo, write_n};
        copy_ee   = (s.cmd == `PPP_CMD_WR_EE);
        keep_ee   = ~s.fuse_hi[`PPP_KEEP_EE_BIT];
        cm1       = s.cnt - 13'h0001;
        fl_we = 1'b0;
        ee_we = 1'b0;
        fb_we = 1'b0;
        eb_we = 1'b0;
        fl_wa = {s.addr_hi[3:0], s.addr_lo};
        fl_ra = {s.addr_hi[3:0], s.addr_lo};
        ee_wa = {s.addr_hi[0], s.addr_lo};
        ee_ra = {s.addr_hi[0], s.addr_lo};
        fb_wa = s.addr_lo[4:0];
        fb_ra = s.cnt[4:0];
        eb_wa = s.addr_lo[1:0];
        eb_ra = s.cnt[1:0];
        fl_wd = 16'hffff;
        ee_wd = 8'hff;
        fb_wd = {data_in, s.data_lo};
        eb_wd = s.data_lo;

        next_s.lclk_q = load_clock_in;
        next_s.wr_n_q = write_n;
        next_s.bsf_q  = byte_select_first;

        // ****************************************
        // Entry into programming mode
        // ****************************************
        unique case (s.en)
            ppp_pkg::EN_OFF: begin
                if (!reset_low) begin
                    next_s.tog_cnt = 3'h0;
                end else if (lclk_tog) begin
                    next_s.tog_cnt = s.tog_cnt + 3'h1;
                    if (s.tog_cnt == 3'(`PPP_ENTRY_TOGGLES - 1)) begin
                        next_s.en = ppp_pkg::EN_ARMED;
                    end
                end
            end
            ppp_pkg::EN_ARMED: begin
                if (reset_hv) begin
                    next_s.settle = 3'h0;
                    next_s.en = (pen == 4'h0) ? ppp_pkg::EN_SETTLE : ppp_pkg::EN_FAIL;
                end else if (!reset_low) begin
                    next_s.tog_cnt = 3'h0;
                    next_s.en = ppp_pkg::EN_OFF;
                end
            end
            ppp_pkg::EN_SETTLE: begin
                if (!reset_hv) begin
                    next_s.en = ppp_pkg::EN_OFF;
                end else if (pen != 4'h0) begin
                    next_s.en = ppp_pkg::EN_FAIL;
                end else if (s.settle == 3'(`PPP_ENTRY_CYC - 1)) begin
                    next_s.en = ppp_pkg::EN_ACTIVE;
                end else begin
                    next_s.settle = s.settle + 3'h1;
                end
            end
            ppp_pkg::EN_ACTIVE, ppp_pkg::EN_FAIL: begin
                // Failed entry stays out until high voltage is removed
                if (!reset_hv) begin
                    next_s.en = ppp_pkg::EN_OFF;
                end
            end
            default: begin
                next_s.en = ppp_pkg::EN_OFF;
            end
        endcase
        if (next_s.en == ppp_pkg::EN_OFF) begin
            next_s.tog_cnt = (s.en == ppp_pkg::EN_OFF) ? next_s.tog_cnt : 3'h0;
            next_s.op = ppp_pkg::OP_IDLE;
            next_s.dirty = 1'b0;
        end

        // ****************************************
        // Loading and operations
        // ****************************************
        if (s.en == ppp_pkg::EN_ACTIVE) begin
            unique case (s.op)
                ppp_pkg::OP_IDLE: begin
                    // Loads are refused while busy; only the idle state takes them
                    if (lclk_rise) begin
                        unique case ({action_sel_hi, action_sel_lo})
                            `PPP_ACT_ADDR: begin
                                if (byte_select_first) begin
                                    next_s.addr_hi = data_in;
                                end else begin
                                    next_s.addr_lo = data_in;
                                end
                            end
                            `PPP_ACT_DATA: begin
                                if (byte_select_first) begin
                                    next_s.data_hi = data_in;
                                    if (s.cmd == `PPP_CMD_WR_FLASH) begin
                                        fb_we = 1'b1;
                                        next_s.dirty = 1'b1;
                                    end
                                end else begin
                                    next_s.data_lo = data_in;
                                end
                            end
                            `PPP_ACT_CMD: begin
                                next_s.cmd = data_in;
                                next_s.dirty = 1'b0;
                            end
                            `PPP_ACT_IDLE: begin
                            end
                        endcase
                    end
                    if (pgl_rise && copy_ee) begin
                        eb_we = 1'b1;
                        next_s.dirty = 1'b1;
                    end
                    if (wr_fall) begin
                        next_s.cnt = 13'h0000;
                        unique case (s.cmd)
                            `PPP_CMD_ERASE: begin
                                next_s.op = ppp_pkg::OP_ERASE;
                            end
                            `PPP_CMD_WR_FUSE: begin
                                // Select pair: 00 low, first only high, second only extended
                                if (byte_select_first) begin
                                    next_s.fuse_hi = s.data_lo;
                                end else if (action_sel_hi) begin
                                    next_s.fuse_ext = s.data_lo;
                                end else begin
                                    next_s.fuse_lo = s.data_lo;
                                end
                                next_s.wait_cnt = FUSE_WAIT;
                                next_s.op = ppp_pkg::OP_WAIT;
                            end
                            `PPP_CMD_WR_LOCK: begin
                                // Lock bits only program; erase is the way back
                                next_s.lock = s.lock & s.data_lo;
                                next_s.wait_cnt = FUSE_WAIT;
                                next_s.op = ppp_pkg::OP_WAIT;
                            end
                            `PPP_CMD_WR_FLASH, `PPP_CMD_WR_EE: begin
                                if (s.dirty) begin
                                    next_s.wait_len = copy_ee ? EE_WAIT : FLASH_WAIT;
                                    next_s.op = ppp_pkg::OP_COPY;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ppp_pkg::OP_COPY: begin
                    // Buffer read is registered, so the array write trails by one count
                    if (s.cnt != 13'h0000) begin
                        if (copy_ee) begin
                            ee_we = 1'b1;
                            ee_wa = {s.addr_hi[0], s.addr_lo[7:2], cm1[1:0]};
                            ee_wd = eb_rd;
                        end else begin
                            fl_we = 1'b1;
                            fl_wa = {s.addr_hi[3:0], s.addr_lo[7:5], cm1[4:0]};
                            fl_wd = fb_rd;
                        end
                    end
                    next_s.cnt = s.cnt + 13'h0001;
                    if (s.cnt == (copy_ee ? `PPP_EE_PAGE : `PPP_FL_PAGE)) begin
                        next_s.dirty = 1'b0;
                        next_s.wait_cnt = s.wait_len;
                        next_s.op = ppp_pkg::OP_WAIT;
                    end
                end
                ppp_pkg::OP_ERASE: begin
                    fl_we = 1'b1;
                    fl_wa = s.cnt[`PPP_FL_AW-1:0];
                    ee_we = ~keep_ee && (s.cnt < `PPP_EE_WORDS);
                    ee_wa = s.cnt[`PPP_EE_AW-1:0];
                    next_s.cnt = s.cnt + 13'h0001;
                    if (s.cnt == `PPP_FL_LAST) begin
                        next_s.lock = 8'hff;
                        next_s.dirty = 1'b0;
                        next_s.wait_cnt = ERASE_WAIT;
                        next_s.op = ppp_pkg::OP_WAIT;
                    end
                end
                ppp_pkg::OP_WAIT: begin
                    next_s.wait_cnt = s.wait_cnt - 20'h00001;
                    if (s.wait_cnt <= 20'h00001) begin
                        next_s.op = ppp_pkg::OP_IDLE;
                    end
                end
                default: begin
                    next_s.op = ppp_pkg::OP_IDLE;
                end
            endcase
        end

        // ****************************************
        // Read-back and outputs
        // ****************************************
        next_s.pm  = (next_s.en == ppp_pkg::EN_ACTIVE);
        next_s.rdy = (next_s.op == ppp_pkg::OP_IDLE);
        next_s.doe = next_s.pm & ~oe_n;
        unique case (s.cmd)
            `PPP_CMD_RD_FLASH: begin
                next_s.dout = byte_select_first ? fl_rd[15:8] : fl_rd[7:0];
            end
            `PPP_CMD_RD_EE: begin
                next_s.dout = ee_rd;
            end
            `PPP_CMD_RD_FUSE: begin
                unique case ({action_sel_hi, byte_select_first})
                    2'h0: next_s.dout = s.fuse_lo;
                    2'h3: next_s.dout = s.fuse_hi;
                    2'h2: next_s.dout = s.fuse_ext;
                    2'h1: next_s.dout = s.lock;
                endcase
            end
            `PPP_CMD_RD_SIG: begin
                if (byte_select_first) begin
                    next_s.dout = CAL_BYTE;
                end else begin
                    unique case (s.addr_lo[1:0])
                        2'h0: next_s.dout = SIG_BYTE0;
                        2'h1: next_s.dout = SIG_BYTE1;
                        2'h2: next_s.dout = SIG_BYTE2;
                        2'h3: next_s.dout = 8'hff;
                    endcase
                end
            end
            default: begin
                next_s.dout = 8'hff;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.en       <= ppp_pkg::EN_OFF;
            s.op       <= ppp_pkg::OP_IDLE;
            s.lclk_q   <= 1'b0;
            s.wr_n_q   <= 1'b1;
            s.wait_len <= 20'h00001;
            s.fuse_lo  <= `PPP_FUSE_LO_RST;
            s.fuse_hi  <= `PPP_FUSE_HI_RST;
            s.fuse_ext <= `PPP_FUSE_EXT_RST;
            s.lock     <= `PPP_LOCK_RST;
            s.dout     <= 8'hff;
            s.rdy      <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign data_out        = s.dout;
    assign data_oe         = s.doe;
    assign ready_busy_flag = s.rdy;
    assign prog_mode       = s.pm;

endmodule

`default_nettype wire

// file: testbench/ppp_port_chk.sv
/* Checker of the programming port pins; bound to the port's top module.
   Assumes one clk domain and nrst as the only reset. */
`default_nettype none
module ppp_port_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       load_clock_in,
    input wire logic       action_sel_lo,
    input wire logic       action_sel_hi,
    input wire logic       byte_select_first,
    input wire logic       write_n,
    input wire logic       oe_n,
    input wire logic       reset_hv,
    input wire logic [7:0] data_in,
    input wire logic       data_oe,
    input wire logic       ready_busy_flag,
    input wire logic       prog_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [7:0]  cmd;
    logic [2:0]  quiet;
    logic [12:0] busy;
    logic        lclk_q;
    wire         pins_zero = !(byte_select_first | action_sel_hi | action_sel_lo | write_n);
    // Mirror of the loaded command; loads are refused while busy
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd <= 8'h00;
            quiet <= 3'h0;
            busy <= 13'h0000;
            lclk_q <= 1'b0;
        end else begin
            lclk_q <= load_clock_in;
            if (load_clock_in && !lclk_q && action_sel_hi && !action_sel_lo && ready_busy_flag && prog_mode) begin
                cmd <= data_in;
            end
            quiet <= (reset_hv && pins_zero) ? quiet + 3'(quiet != 3'h7) : 3'h0;
            busy <= ready_busy_flag ? 13'h0000 : busy + 13'(busy != 13'h1fff);
        end
    end
    sequence s_erase_go;
        cmd == 8'h80 && prog_mode && ready_busy_flag && $fell(write_n);
    endsequence
    chk_erase_busy: assert property (s_erase_go |-> ##[1:3] !ready_busy_flag) else $error("erase not busy");
    chk_erase_sweep: assert property ($rose(ready_busy_flag) && cmd == 8'h80 |-> busy > 13'h0fff)
        else $error("erase too short");
    chk_busy_hold: assert property ($fell(ready_busy_flag) |-> !ready_busy_flag [*3])
        else $error("busy glitch");
    chk_idle_ready: assert property (!prog_mode |-> ready_busy_flag) else $error("busy outside mode");
    chk_oe_drive: assert property (prog_mode && !oe_n && reset_hv |=> data_oe) else $error("bus not driven");
    chk_oe_release: assert property (oe_n |=> !data_oe) else $error("bus driven while oe high");
    chk_entry_quiet: assert property ($rose(prog_mode) |-> quiet >= 3'h4)
        else $error("entry without quiet pins");
    chk_hv_drop: assert property (!reset_hv |=> !prog_mode) else $error("mode without high voltage");
endmodule
bind ppp_port ppp_port_chk i_ppp_port_chk (.clk, .nrst, .load_clock_in, .action_sel_lo, .action_sel_hi,
    .byte_select_first, .write_n, .oe_n, .reset_hv, .data_in, .data_oe, .ready_busy_flag, .prog_mode);
`default_nettype wire

// file: testbench/ppp_prog_model.sv
/* Programmer model driving the port pins, load and write pulses ten clocks long, read pulses eleven.
   Assumes a 25 ns clk; the bench merges pd with the device's bus. */
`default_nettype none
module ppp_prog_model (
    input  wire logic       clk,
    input  wire logic       rdy,
    output var  logic       rst_lo,
    output var  logic       rst_hv,
    output var  logic       lclk,
    output var  logic       asl,
    output var  logic       ash,
    output var  logic       bsf,
    output var  logic       wr_n,
    output var  logic       oe_n,
    output var  logic [7:0] pd,
    output var  logic       smp
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {rst_lo, rst_hv, lclk, asl, ash, bsf, smp} = 7'h00;
        {wr_n, oe_n} = 2'h3;
        pd = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic enter();
        rst_lo <= 1'b1;
        repeat (6) begin
            hold(10);
            lclk <= ~lclk;
        end
        {ash, asl, bsf, wr_n} <= 4'h0;
        hold(10);
        rst_hv <= 1'b1;
        rst_lo <= 1'b0;
        hold(2000);
        wr_n <= 1'b1;
        hold(10);
    endtask
    task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
        {ash, asl, bsf} <= {a, b};
        pd <= d;
        hold(10);
        lclk <= 1'b1;
        hold(10);
        lclk <= 1'b0;
        hold(10);
    endtask
    task automatic wr();
        {ash, asl, bsf} <= 3'h0;
        wr_n <= 1'b0;
        hold(10);
        wr_n <= 1'b1;
        for (int n = 0; n < 20000 && rdy !== 1'b1; n++) hold(1);
        hold(2);
    endtask
    task automatic rd(input logic a, input logic b);
        {ash, asl, bsf} <= {a, 1'b0, b};
        oe_n <= 1'b0;
        // Released bus shows the inverse of its last value
        pd <= ~pd;
        hold(10);
        smp <= 1'b1;
        hold(1);
        smp <= 1'b0;
        oe_n <= 1'b1;
        hold(2);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb_ppp_port.sv
/* Bench of the programming port: the model drives, a monitor compares
   flags and bus at each read. Assumes shortened write waits. */
`default_nettype none
module tb_ppp_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, nrst, rdy, pm, doe, lclk, asl, ash, bsf, wr_n, oe_n, smp, rst_lo, rst_hv;
    logic [7:0]  pd, dout, bus, r;
    logic [10:0] e;
    logic [10:0] exp_q[$];
    int          fail_count, comparisons;
    assign bus = doe ? dout : pd;
    always #12.5 clk = ~clk;
    ppp_port #(.FLASH_WAIT(20'h00004), .EE_WAIT(20'h00004), .ERASE_WAIT(20'h00004), .FUSE_WAIT(20'h00004))
    i_ppp_port (.clk, .nrst, .ce(1'b1), .reset_low(rst_lo), .reset_hv(rst_hv), .load_clock_in(lclk),
        .action_sel_lo(asl), .action_sel_hi(ash), .byte_select_first(bsf), .write_n(wr_n), .oe_n,
        .data_in(bus), .data_out(dout), .data_oe(doe), .ready_busy_flag(rdy), .prog_mode(pm));
    ppp_prog_model i_ppp_prog_model (.clk, .rdy, .rst_lo, .rst_hv, .lclk, .asl, .ash, .bsf, .wr_n, .oe_n, .pd, .smp);
    always @(posedge clk) begin
        if (smp) begin
            e = exp_q.pop_front();
            comparisons++;
            if ({rdy, pm, doe, bus} !== e) begin
                $display("MISMATCH t=%0t got %h exp %h", $time, {rdy, pm, doe, bus}, e);
                fail_count++;
            end
        end
    end
    task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        i_ppp_prog_model.load(a, b, d);
    endtask
    task automatic rd(input logic a, input logic b, input logic [7:0] v);
        exp_q.push_back({3'h7, v});
        i_ppp_prog_model.rd(a, b);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        void'($urandom(25));
        r = 8'($urandom);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        i_ppp_prog_model.enter();
        ld(2'h2, 1'b0, 8'h04);
        rd(1'b0, 1'b0, 8'h62);
        rd(1'b1, 1'b1, 8'hdf);
        rd(1'b1, 1'b0, 8'hff);
        rd(1'b0, 1'b1, 8'hff);
        ld(2'h2, 1'b0, 8'h40);
        ld(2'h1, 1'b0, r);
        i_ppp_prog_model.wr();
        ld(2'h2, 1'b0, 8'h20);
        ld(2'h1, 1'b0, 8'hfc);
        i_ppp_prog_model.wr();
        ld(2'h2, 1'b0, 8'h04);
        rd(1'b0, 1'b0, r);
        rd(1'b0, 1'b1, 8'hfc);
        ld(2'h2, 1'b0, 8'h80);
        i_ppp_prog_model.wr();
        ld(2'h2, 1'b0, 8'h04);
        rd(1'b0, 1'b0, r);
        rd(1'b0, 1'b1, 8'hff);
        ld(2'h2, 1'b0, 8'h10);
        ld(2'h0, 1'b0, r);
        ld(2'h1, 1'b0, ~r);
        ld(2'h1, 1'b1, r ^ 8'h5a);
        ld(2'h0, 1'b1, 8'h03);
        i_ppp_prog_model.wr();
        ld(2'h2, 1'b0, 8'h02);
        rd(1'b0, 1'b0, ~r);
        rd(1'b0, 1'b1, r ^ 8'h5a);
        ld(2'h2, 1'b0, 8'h03);
        rd(1'b0, 1'b0, 8'hff);
        ld(2'h2, 1'b0, 8'h08);
        rd(1'b0, 1'b1, 8'h80);
        ld(2'h2, 1'b0, 8'h00);
        ld(2'h3, 1'b0, 8'h04);
        rd(1'b0, 1'b0, 8'hff);
        give_verdict();
    end
endmodule
`default_nettype wire
